// File: ofp_meas_model.sv
// Purpose: Upstream estimator stand-in, one filtered estimate per voltage signal
// Assumes: Commanded values change just after a rising edge
// Notes: No filter dynamics, so a step reaches the stages at once
module ofp_meas_model (
    // Commanded quantities
    input wire logic [2:0][16:0] i_freq,
    input wire logic [2:0][11:0] i_mag,
    // Estimates
    output ofp_pkg::meas_t [2:0] o_meas
);
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            o_meas[k] = {i_freq[k], i_mag[k]};
        end
    end
endmodule : ofp_meas_model

// File: ofp_pkg.sv
// Purpose: Constants, types and register map for the five-stage overfrequency element
// Assumes: 50 MHz system clock; measurements arrive already filtered, on the same clock
// Notes: Frequencies in mHz, per-unit quantities in thousandths of rated value
// What this block does
// [R1] Five independent definite-time stages, each switchable
// [R2] Frequency from up to three voltage signals
// [R3] Only signals above stage undervoltage threshold count
// [R4] Pickup needs condition on every live signal
// [R5] Pickup and trip reported separately per stage
// [R6] Pickup when frequency exceeds stage threshold
// [R7] Reset level fixed 20 mHz below pickup
// [R8] Threshold per unit times 50 or 60 Hz
// [R9] Thresholds allowed above or below rated frequency
// [R10] Trip after constant delay; zero trips at once
// [R11] Reset at once below reset level
// [R12] Per-stage block plus general block input
// [R13] Undervoltage block only when all signals low
// [R14] Undervoltage block resets a picked-up stage
// [R15] Blocked flag plus separate undervoltage-blocked flag
// [R16] Health alarm, no operation, on bad channel
// [R17] Blocked stage: no pickup, trip; timer cleared
// [R18] Upstream supplies filtered frequency and magnitudes
// [R19] Delay 0 to 120000 ms, default 200
// [R20] Threshold 0.8 to 1.2 pu, default 1.05
// [R21] Undervoltage threshold 0.15 to 1.0, default 0.8
package ofp_pkg;
    localparam int NUM_STAGES = 5;
    localparam int NUM_SIGNALS = 3;
    localparam int FREQ_W = 17;
    localparam int PU_W = 11;
    localparam int MAG_W = 12;
    localparam int DLY_W = 17;
    localparam int SUB_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Setting ranges and factory values
    localparam logic [PU_W-1:0] THR_MIN = 11'h320;
    localparam logic [PU_W-1:0] THR_MAX = 11'h4b0;
    localparam logic [PU_W-1:0] THR_RESET = 11'h41a;
    localparam logic [PU_W-1:0] UV_MIN = 11'h096;
    localparam logic [PU_W-1:0] UV_MAX = 11'h3e8;
    localparam logic [PU_W-1:0] UV_RESET = 11'h320;
    localparam logic [DLY_W-1:0] DLY_MAX = 17'h1d4c0;
    localparam logic [DLY_W-1:0] DLY_RESET = 17'h000c8;
    localparam logic [FREQ_W-1:0] DROPOUT_MHZ = 17'h00014;
    localparam logic [FREQ_W-1:0] RATED_LOW_HZ = 17'h00032;
    localparam logic [FREQ_W-1:0] RATED_HIGH_HZ = 17'h0003c;

    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;

    // Register map: stage s occupies address s*0x10 from 0x00, one word per field
    localparam logic [ADDR_W-1:0] STAGE_LAST_ADDR = 8'h4c;
    localparam logic [1:0] FLD_ENABLE = 2'h0;
    localparam logic [1:0] FLD_FREQ = 2'h1;
    localparam logic [1:0] FLD_DELAY = 2'h2;
    localparam logic [1:0] FLD_UV = 2'h3;
    localparam logic [ADDR_W-1:0] CONFIG_ADDR = 8'h50;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h54;

    // Config fields
    localparam int CFG_RATED_BIT = 0;
    localparam int CFG_ASSIGNED_BIT = 1;
    localparam int CFG_NEUTRAL_BIT = 2;
    localparam int CFG_PRESENT_LSB = 3;
    localparam int CFG_W = 6;
    localparam logic [CFG_W-1:0] CONFIG_RESET = 6'h00;

    // Status fields
    localparam int STS_PICKUP_LSB = 0;
    localparam int STS_TRIP_LSB = 8;
    localparam int STS_INHIB_LSB = 16;
    localparam int STS_LOWV_LSB = 24;
    localparam int STS_HEALTH_BIT = 31;

    typedef struct packed {
        logic [FREQ_W-1:0] freq_mhz;
        logic [MAG_W-1:0] mag;
    } meas_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [NUM_STAGES-1:0] pickup;
        logic [NUM_STAGES-1:0] trip;
        logic [NUM_STAGES-1:0] inhibited;
        logic [NUM_STAGES-1:0] low_voltage_inhibited;
    } stage_flags_t;

    typedef enum logic [2:0] {
        STAGE_IDLE = 3'b001,
        STAGE_TIMING = 3'b010,
        STAGE_TRIPPED = 3'b100
    } stage_state_t;

    function automatic logic [DATA_W-1:0] clamp(input logic [DATA_W-1:0] v,
                                                input logic [DATA_W-1:0] lo,
                                                input logic [DATA_W-1:0] hi);
        logic [DATA_W-1:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction : clamp
endpackage : ofp_pkg

// File: ofp_sva.sv
// Purpose: Port-level checks for the five overfrequency stages
// Assumes: One clock, synchronous active-low reset
// Notes: Settings are invisible here, so every check holds for any setting
module ofp_sva #(
    parameter int CYCLES_PER_MS = 4
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Register port
    input wire ofp_pkg::reg_req_t i_reg_req,
    input wire logic [ofp_pkg::DATA_W-1:0] o_reg_rdata,
    // Stage inputs and outputs
    input wire ofp_pkg::meas_t [ofp_pkg::NUM_SIGNALS-1:0] i_meas,
    input wire logic [ofp_pkg::NUM_STAGES-1:0] i_stage_inhibit_input,
    input wire logic i_general_inhibit_input,
    input wire ofp_pkg::stage_flags_t o_stage_flags,
    input wire logic o_health_alarm
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    sequence s_gen_held;
        i_general_inhibit_input ##1 1'b1;
    endsequence

    // Zero magnitude can never exceed the smallest allowed undervoltage threshold
    sequence s_dead;
        (i_meas[0].mag == '0 && i_meas[1].mag == '0 && i_meas[2].mag == '0) ##1 1'b1;
    endsequence

    a_trip_in_pickup: assert property ((o_stage_flags.trip & ~o_stage_flags.pickup) == '0)
        else $error("trip without pickup");
    a_alarm_quiet: assert property (o_health_alarm && $past(o_health_alarm) |->
        (o_stage_flags.pickup | o_stage_flags.trip | o_stage_flags.inhibited) == '0) else $error("alarm not quiet");
    a_gen_block: assert property (s_gen_held |-> (o_stage_flags.pickup | o_stage_flags.trip) == '0)
        else $error("general block ignored");
    a_stage_block: assert property (($past(i_stage_inhibit_input) & o_stage_flags.pickup) == '0)
        else $error("stage block ignored");
    a_lowv_inhib: assert property ((o_stage_flags.low_voltage_inhibited & ~o_stage_flags.inhibited) == '0)
        else $error("low voltage flag without blocked flag");
    a_lowv_reset: assert property ((o_stage_flags.low_voltage_inhibited & o_stage_flags.pickup) == '0)
        else $error("pickup during undervoltage block");
    a_dead_quiet: assert property (s_dead |-> o_stage_flags.pickup == '0)
        else $error("pickup with no live signal");
    a_rdata_idle: assert property (!$past(i_reg_req.rd) |-> o_reg_rdata == '0)
        else $error("read data outside read slot");
    a_status_mirror: assert property ($past(i_rst_n) && $past(i_reg_req.rd) &&
        $past(i_reg_req.addr) == ofp_pkg::STATUS_ADDR |-> o_reg_rdata == {$past(o_health_alarm), 2'b0,
        $past(o_stage_flags.low_voltage_inhibited), 3'b0, $past(o_stage_flags.inhibited), 3'b0,
        $past(o_stage_flags.trip), 3'b0, $past(o_stage_flags.pickup)}) else $error("status word differs from flags");
endmodule : ofp_sva

bind overfreq_stages ofp_sva #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_sva (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata), .i_meas(i_meas),
    .i_stage_inhibit_input(i_stage_inhibit_input), .i_general_inhibit_input(i_general_inhibit_input),
    .o_stage_flags(o_stage_flags), .o_health_alarm(o_health_alarm));

// File: overfreq_stages.sv
// Purpose: Five-stage definite-time overfrequency element with undervoltage and user blocking
// Assumes: Measurement and block inputs are produced by logic on i_clk_sys
// Notes: Settings live in a small register file; out-of-range writes are clamped
module overfreq_stages #(
    parameter int CYCLES_PER_MS = ofp_pkg::CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Register port
    input wire ofp_pkg::reg_req_t i_reg_req,
    output logic [ofp_pkg::DATA_W-1:0] o_reg_rdata,
    // Measurements, one per voltage signal
    input wire ofp_pkg::meas_t [ofp_pkg::NUM_SIGNALS-1:0] i_meas,
    // Block inputs
    input wire logic [ofp_pkg::NUM_STAGES-1:0] i_stage_inhibit_input,
    input wire logic i_general_inhibit_input,
    // Stage indications
    output ofp_pkg::stage_flags_t o_stage_flags,
    output logic o_health_alarm
);
    localparam int NS = ofp_pkg::NUM_STAGES;
    localparam int NV = ofp_pkg::NUM_SIGNALS;
    localparam logic [ofp_pkg::SUB_W-1:0] SUB_LAST = ofp_pkg::SUB_W'(CYCLES_PER_MS - 1);

    logic [NS-1:0] stage_enable_setting;
    logic [NS-1:0] next_stage_enable_setting;
    logic [ofp_pkg::PU_W-1:0] stage_frequency_threshold [NS];
    logic [ofp_pkg::PU_W-1:0] next_stage_frequency_threshold [NS];
    logic [ofp_pkg::DLY_W-1:0] stage_trip_delay [NS];
    logic [ofp_pkg::DLY_W-1:0] next_stage_trip_delay [NS];
    logic [ofp_pkg::PU_W-1:0] stage_low_voltage_threshold [NS];
    logic [ofp_pkg::PU_W-1:0] next_stage_low_voltage_threshold [NS];
    logic [ofp_pkg::CFG_W-1:0] config_reg;
    logic [ofp_pkg::CFG_W-1:0] next_config_reg;
    logic [ofp_pkg::DATA_W-1:0] next_reg_rdata;

    logic [ofp_pkg::FREQ_W-1:0] rated_hz;
    logic [NV-1:0] present;
    logic [ofp_pkg::DATA_W-1:0] status_word;

    // Register file: word-aligned accesses only, unmapped reads return zero
    always_comb begin
        logic is_stage;
        logic [3:0] sel;
        logic [1:0] fld;
        is_stage = (i_reg_req.addr <= ofp_pkg::STAGE_LAST_ADDR) && (i_reg_req.addr[1:0] == 2'h0);
        sel = i_reg_req.addr[7:4];
        fld = i_reg_req.addr[3:2];
        next_stage_enable_setting = stage_enable_setting;
        next_config_reg = config_reg;
        next_reg_rdata = '0;
        for (int s = 0; s < NS; s++) begin
            next_stage_frequency_threshold[s] = stage_frequency_threshold[s];
            next_stage_trip_delay[s] = stage_trip_delay[s];
            next_stage_low_voltage_threshold[s] = stage_low_voltage_threshold[s];
            if (is_stage && sel == 4'(s)) begin
                if (i_reg_req.wr) begin
                    case (fld)
                        ofp_pkg::FLD_ENABLE: next_stage_enable_setting[s] = i_reg_req.wdata[0]; // R1
                        ofp_pkg::FLD_FREQ: next_stage_frequency_threshold[s] = ofp_pkg::PU_W'(ofp_pkg::clamp(
                            i_reg_req.wdata, 32'(ofp_pkg::THR_MIN), 32'(ofp_pkg::THR_MAX))); // R20 R9
                        ofp_pkg::FLD_DELAY: next_stage_trip_delay[s] = ofp_pkg::DLY_W'(ofp_pkg::clamp(
                            i_reg_req.wdata, 32'h0, 32'(ofp_pkg::DLY_MAX))); // R19
                        ofp_pkg::FLD_UV: next_stage_low_voltage_threshold[s] = ofp_pkg::PU_W'(ofp_pkg::clamp(
                            i_reg_req.wdata, 32'(ofp_pkg::UV_MIN), 32'(ofp_pkg::UV_MAX))); // R21
                        default: next_stage_enable_setting[s] = stage_enable_setting[s];
                    endcase
                end
                if (i_reg_req.rd) begin
                    case (fld)
                        ofp_pkg::FLD_ENABLE: next_reg_rdata = 32'(stage_enable_setting[s]);
                        ofp_pkg::FLD_FREQ: next_reg_rdata = 32'(stage_frequency_threshold[s]);
                        ofp_pkg::FLD_DELAY: next_reg_rdata = 32'(stage_trip_delay[s]);
                        ofp_pkg::FLD_UV: next_reg_rdata = 32'(stage_low_voltage_threshold[s]);
                        default: next_reg_rdata = '0;
                    endcase
                end
            end
        end
        if (i_reg_req.addr == ofp_pkg::CONFIG_ADDR) begin
            if (i_reg_req.wr) begin
                next_config_reg = i_reg_req.wdata[ofp_pkg::CFG_W-1:0];
            end
            if (i_reg_req.rd) begin
                next_reg_rdata = 32'(config_reg);
            end
        end
        if (i_reg_req.addr == ofp_pkg::STATUS_ADDR && i_reg_req.rd) begin
            next_reg_rdata = status_word;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            stage_enable_setting <= '0;
            config_reg <= ofp_pkg::CONFIG_RESET;
            o_reg_rdata <= '0;
            for (int s = 0; s < NS; s++) begin
                stage_frequency_threshold[s] <= ofp_pkg::THR_RESET;
                stage_trip_delay[s] <= ofp_pkg::DLY_RESET;
                stage_low_voltage_threshold[s] <= ofp_pkg::UV_RESET;
            end
        end else begin
            stage_enable_setting <= next_stage_enable_setting;
            config_reg <= next_config_reg;
            o_reg_rdata <= next_reg_rdata;
            for (int s = 0; s < NS; s++) begin
                stage_frequency_threshold[s] <= next_stage_frequency_threshold[s];
                stage_trip_delay[s] <= next_stage_trip_delay[s];
                stage_low_voltage_threshold[s] <= next_stage_low_voltage_threshold[s];
            end
        end
    end

    // Channel configuration decides health; a neutral channel carries no usable frequency
    assign o_health_alarm = ~config_reg[ofp_pkg::CFG_ASSIGNED_BIT] | config_reg[ofp_pkg::CFG_NEUTRAL_BIT]; // R16
    assign rated_hz = config_reg[ofp_pkg::CFG_RATED_BIT] ? ofp_pkg::RATED_HIGH_HZ : ofp_pkg::RATED_LOW_HZ; // R8
    assign present = config_reg[ofp_pkg::CFG_PRESENT_LSB +: NV]; // R2

    always_comb begin
        status_word = '0;
        status_word[ofp_pkg::STS_PICKUP_LSB +: NS] = o_stage_flags.pickup;
        status_word[ofp_pkg::STS_TRIP_LSB +: NS] = o_stage_flags.trip;
        status_word[ofp_pkg::STS_INHIB_LSB +: NS] = o_stage_flags.inhibited;
        status_word[ofp_pkg::STS_LOWV_LSB +: NS] = o_stage_flags.low_voltage_inhibited;
        status_word[ofp_pkg::STS_HEALTH_BIT] = o_health_alarm;
    end

    for (genvar s = 0; s < NS; s++) begin : g_stage
        logic [ofp_pkg::FREQ_W-1:0] pick_lvl;
        logic [ofp_pkg::FREQ_W-1:0] reset_lvl;
        logic [NV-1:0] live;
        logic [NV-1:0] low;
        logic [NV-1:0] above;
        logic cond;
        logic uv_block;
        logic inhibit;
        logic run;
        ofp_pkg::stage_state_t state;
        ofp_pkg::stage_state_t next_state;
        logic [ofp_pkg::SUB_W-1:0] sub;
        logic [ofp_pkg::SUB_W-1:0] next_sub;
        logic [ofp_pkg::DLY_W-1:0] ms;
        logic [ofp_pkg::DLY_W-1:0] next_ms;
        logic inhibited;
        logic next_inhibited;
        logic low_v;
        logic next_low_v;

        always_comb begin
            pick_lvl = ofp_pkg::FREQ_W'(stage_frequency_threshold[s]) * rated_hz; // R8
            reset_lvl = pick_lvl - ofp_pkg::DROPOUT_MHZ; // R7
            for (int i = 0; i < NV; i++) begin
                live[i] = present[i] &&
                    (i_meas[i].mag > ofp_pkg::MAG_W'(stage_low_voltage_threshold[s])); // R3
                low[i] = i_meas[i].mag < ofp_pkg::MAG_W'(stage_low_voltage_threshold[s]);
                // Picked-up stages hold until below the reset level, idle ones need the pickup level
                above[i] = (state == ofp_pkg::STAGE_IDLE) ? (i_meas[i].freq_mhz > pick_lvl) // R6
                                                          : (i_meas[i].freq_mhz >= reset_lvl); // R11
            end
            cond = (|live) && (&(above | ~live)); // R4
            uv_block = &(low | ~present); // R13
            inhibit = i_stage_inhibit_input[s] | i_general_inhibit_input | uv_block; // R12
            run = stage_enable_setting[s] & ~o_health_alarm & ~inhibit; // R1 R16 R17
            next_inhibited = stage_enable_setting[s] & ~o_health_alarm & inhibit; // R15
            next_low_v = stage_enable_setting[s] & ~o_health_alarm & uv_block; // R15
            next_state = state;
            next_sub = sub;
            next_ms = ms;
            if (!run || !cond) begin
                // Immediate reset with timer cleared, also when undervoltage bites mid-timing
                next_state = ofp_pkg::STAGE_IDLE; // R11 R14 R17
                next_sub = '0;
                next_ms = '0;
            end else begin
                case (state)
                    ofp_pkg::STAGE_IDLE: begin
                        next_sub = '0;
                        next_ms = '0;
                        next_state = (stage_trip_delay[s] == '0) ? ofp_pkg::STAGE_TRIPPED // R10
                                                                 : ofp_pkg::STAGE_TIMING;
                    end
                    ofp_pkg::STAGE_TIMING: begin
                        next_sub = sub + 1'b1;
                        if (sub == SUB_LAST) begin
                            next_sub = '0;
                            next_ms = ms + 1'b1;
                            if (next_ms >= stage_trip_delay[s]) begin
                                next_state = ofp_pkg::STAGE_TRIPPED; // R10
                            end
                        end
                    end
                    ofp_pkg::STAGE_TRIPPED: next_state = ofp_pkg::STAGE_TRIPPED;
                    default: next_state = ofp_pkg::STAGE_IDLE;
                endcase
            end
        end

        always_ff @(posedge i_clk_sys) begin
            if (!i_rst_n) begin
                state <= ofp_pkg::STAGE_IDLE;
                sub <= '0;
                ms <= '0;
                inhibited <= 1'b0;
                low_v <= 1'b0;
            end else begin
                state <= next_state;
                sub <= next_sub;
                ms <= next_ms;
                inhibited <= next_inhibited;
                low_v <= next_low_v;
            end
        end

        // Flags decode straight from one-hot state bits, so they stay flop outputs
        assign o_stage_flags.pickup[s] = ~state[0]; // R5
        assign o_stage_flags.trip[s] = state[2]; // R5
        assign o_stage_flags.inhibited[s] = inhibited;
        assign o_stage_flags.low_voltage_inhibited[s] = low_v;
    end
endmodule : overfreq_stages

// File: tb.sv
// Purpose: Self-checking bench for the overfrequency stages
// Assumes: Millisecond shortened to 4 cycles
// Notes: Each stage in turn is enabled alone, so other stages must stay silent
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CPM = 4;
    logic i_clk_sys;
    logic i_rst_n;
    ofp_pkg::reg_req_t req;
    logic [31:0] rdata;
    ofp_pkg::meas_t [2:0] meas;
    logic [2:0][16:0] freq;
    logic [2:0][11:0] mag;
    logic [4:0] stg_inh;
    logic gen_inh;
    ofp_pkg::stage_flags_t flags;
    logic alarm;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;

    ofp_meas_model u_model (.i_freq(freq), .i_mag(mag), .o_meas(meas));
    overfreq_stages #(.CYCLES_PER_MS(CPM)) uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_req(req),
        .o_reg_rdata(rdata), .i_meas(meas), .i_stage_inhibit_input(stg_inh), .i_general_inhibit_input(gen_inh),
        .o_stage_flags(flags), .o_health_alarm(alarm));

    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk_sys);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk_sys);
        req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk_sys);
        req.rd <= 1'b0;
        @(negedge i_clk_sys);
        chk(rdata, exp);
    endtask : rd

    task automatic put(input int f0, f1, f2, m0, m1, m2);
        @(posedge i_clk_sys);
        freq <= {17'(f2), 17'(f1), 17'(f0)};
        mag <= {12'(m2), 12'(m1), 12'(m0)};
    endtask : put

    task automatic fl(input logic [4:0] p, t, i, l);
        @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk(32'(flags), 32'({p, t, i, l}));
    endtask : fl

    // Bounded wait: a stuck timer shows as a wrong count, not a hang
    task automatic tw(input int s, d);
        int n;
        n = 0;
        while (flags.trip[s] !== 1'b1 && n < 64) begin
            @(negedge i_clk_sys);
            n++;
        end
        chk(32'(n), 32'(d * CPM));
    endtask : tw

    function automatic int pick(input int thr, input int r60);
        return thr * ((r60 != 0) ? 60 : 50);
    endfunction : pick

    initial begin
        int s, thr, dly, pk, k;
        logic [4:0] p, tz;
        req = '0;
        freq = '0;
        mag = '0;
        stg_inh = '0;
        gen_inh = 1'b0;
        i_rst_n = 1'b0;
        void'($urandom(32'h88a5da63));
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        wr(ofp_pkg::STATUS_ADDR, 32'hffffffff);
        rd(ofp_pkg::STATUS_ADDR, 32'h80000000);
        for (s = 0; s < 5; s++) begin
            rd(8'(s * 16), 32'h0);
            rd(8'(s * 16 + 4), 32'(ofp_pkg::THR_RESET));
            rd(8'(s * 16 + 8), 32'(ofp_pkg::DLY_RESET));
            rd(8'(s * 16 + 12), 32'(ofp_pkg::UV_RESET));
        end
        wr(8'h04, 32'd500);
        rd(8'h04, 32'(ofp_pkg::THR_MIN));
        wr(8'h08, 32'd200000);
        rd(8'h08, 32'(ofp_pkg::DLY_MAX));
        wr(8'h0c, 32'd2000);
        rd(8'h0c, 32'(ofp_pkg::UV_MAX));
        rd(8'h60, 32'h0);
        $display("test registers done");
        for (s = 0; s < 5; s++) begin
            thr = (s == 1) ? 900 : 800 + $urandom_range(400);
            dly = (s == 0) ? 0 : $urandom_range(3);
            pk = pick(thr, s % 2);
            p = 5'(1 << s);
            tz = (dly == 0) ? p : 5'h0;
            wr(ofp_pkg::CONFIG_ADDR, 32'h3a | 32'(s % 2));
            wr(8'(s * 16 + 4), 32'(thr));
            wr(8'(s * 16 + 8), 32'(dly));
            wr(8'(s * 16 + 12), 32'd800);
            // Settle inputs before enabling: stale levels from the last stage could pick this one up
            put(pk, pk, pk, 900, 900, 900);
            wr(8'(s * 16), 32'h1);
            fl(0, 0, 0, 0);
            put(pk + 1, pk + 1, pk + 1, 900, 900, 900);
            fl(p, tz, 0, 0);
            tw(s, dly);
            put(pk - 20, pk - 20, pk - 20, 900, 900, 900);
            fl(p, p, 0, 0);
            put(pk - 21, pk - 21, pk - 21, 900, 900, 900);
            fl(0, 0, 0, 0);
            put(pk + 1, pk + 1, pk - 21, 900, 900, 100);
            fl(p, tz, 0, 0);
            put(pk + 1, pk + 1, pk - 21, 900, 900, 900);
            fl(0, 0, 0, 0);
            wr(ofp_pkg::CONFIG_ADDR, 32'h0a | 32'(s % 2));
            put(pk + 1, pk - 21, pk - 21, 900, 900, 900);
            fl(p, tz, 0, 0);
            wr(ofp_pkg::CONFIG_ADDR, 32'h3a | 32'(s % 2));
            put(pk + 1, pk + 1, pk + 1, 900, 900, 900);
            fl(p, tz, 0, 0);
            put(pk + 1, pk + 1, pk + 1, 100, 100, 100);
            fl(0, 0, p, p);
            rd(ofp_pkg::STATUS_ADDR, (32'(p) << ofp_pkg::STS_INHIB_LSB) | (32'(p) << ofp_pkg::STS_LOWV_LSB));
            put(pk + 1, pk + 1, pk + 1, 100, 900, 100);
            fl(p, tz, 0, 0);
            for (k = 0; k < 2; k++) begin
                @(posedge i_clk_sys);
                gen_inh <= (k == 1);
                stg_inh <= (k == 0) ? p : 5'h0;
                fl(0, 0, p, 0);
                @(posedge i_clk_sys);
                gen_inh <= 1'b0;
                stg_inh <= 5'h0;
                fl(p, tz, 0, 0);
                tw(s, dly);
            end
            for (k = 0; k < 2; k++) begin
                wr(ofp_pkg::CONFIG_ADDR, (k == 0) ? 32'h38 : 32'h3e);
                fl(0, 0, 0, 0);
                chk(32'(alarm), 32'h1);
            end
            wr(8'(s * 16), 32'h0);
            $display("test stage %0d done", s);
        end
        conclude();
    end
endmodule : tb
